// ===== adc_ctrl_regs.svh
// Register offsets, field positions and reset values of the ADC control block
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define NUM_CHANNELS 21
`define NUM_CMPS 4
`define NUM_TRIG_REGS 11
`define OFS_IE_LOW 8'h00
`define OFS_IE_HIGH 8'h04
`define OFS_RDY_LOW 8'h08
`define OFS_RDY_HIGH 8'h0C
`define OFS_TRIG_BASE 8'h10
`define OFS_CMP_BASE 8'h40
`define CMP_STRIDE 8'h10
`define CMP_CON_OFS 8'h00
`define CMP_MASK_OFS 8'h04
`define HIGH_HALF_BITS 5
`define TRIG_ODD_LSB 8
`define TRIG_EVEN_LSB 0
`define CON_CHNL_LSB 8
`define CON_ON_BIT 7
`define CON_IRQ_BIT 6
`define CON_STAT_BIT 5
`define CON_WINDOW_INSIDE_CRITERION_BIT 4
`define CON_AT_OR_ABOVE_HIGH_CRITERION_BIT 3
`define CON_BELOW_HIGH_CRITERION_BIT 2
`define CON_AT_OR_ABOVE_LOW_CRITERION_BIT 1
`define CON_BELOW_LOW_CRITERION_BIT 0
`define CON_WR_MASK 8'hDF
`define VALID_TRIG_CODES 32'hFFF0_0FF6
`define RESET_HALF 16'h0000
`define RESET_MASK 21'h000000
`endif

// ===== adc_ctrl_pkg.sv
// Types shared by the ADC control block
package adc_ctrl_pkg;
   typedef logic [4:0] chan_t;
   typedef logic [4:0] trig_code_t;
   typedef logic [15:0] sample_t;
   typedef logic [20:0] chan_mask_t;
   typedef logic [7:0] wb_addr_t;
endpackage

// ===== adc_trigger_ready_compare.sv
// ADC interrupt enables, ready flags, trigger selection and digital comparators
//
// Contract
// - Channel enable gates common and individual interrupts
// - Unused register bits always read zero
// - Result stored sets that channel's ready flag
// - Ready flags hardware only, writes ignored
// - Trigger register: odd 12:8, even 4:0
// - Code zero untriggered; 1,2 software; 3 reserved
// - Codes 4 to 11 select PWM triggers
// - Codes 12-19 reserved; 20-23 capture compare
// - Codes 24-31 second PWM, logic cells, sequencer, pin
// - Hardware writes event channel number field
// - Comparator on bit enables; clear drops flag
// - Comparator irq enable raises common interrupt
// - Event flag set; cleared reading channel field
// - Window: low <= result < high
// - Result at or above high threshold
// - Result below high threshold
// - Result at or above low threshold
// - Result below low threshold
// - Four independent comparators, own control register
// - Only masked-in channels are compared
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_trigger_ready_compare (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire adc_ctrl_pkg::wb_addr_t I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic I_RESULT_VALID,
   input wire adc_ctrl_pkg::chan_t I_RESULT_CHANNEL,
   input wire adc_ctrl_pkg::sample_t I_RESULT_DATA,
   input wire logic I_BUF_READ,
   input wire adc_ctrl_pkg::chan_t I_BUF_READ_CHANNEL,
   input wire logic [63:0] I_CMP_LOW_THRESHOLD,
   input wire logic [63:0] I_CMP_HIGH_THRESHOLD,
   input wire logic [31:0] I_TRIGGER_SOURCES,
   output logic [20:0] O_CHANNEL_TRIGGER,
   output logic [20:0] O_CHANNEL_IRQ,
   output logic O_COMMON_IRQ,
   output logic [3:0] O_CMP_EVENT
);
   import adc_ctrl_pkg::*;

   logic ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic wr_go;
   logic rd_go;
   chan_mask_t irq_en_reg;
   chan_mask_t ready_reg;
   trig_code_t trig_src_reg [`NUM_CHANNELS];
   logic [20:0] trig_reg;
   logic [20:0] chan_irq_reg;
   logic common_irq_reg;
   logic [7:0] con_rd [`NUM_CMPS];
   chan_t chnl_rd [`NUM_CMPS];
   chan_mask_t cmask_rd [`NUM_CMPS];
   logic [3:0] cmp_hit;
   logic [3:0] cmp_irq_on;
   logic [3:0] cmp_event_reg;
   logic result_in_range;
   logic chan_irq_any;

   // Ack is registered so it drops by itself the cycle after it is given
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= I_WB_CYC & I_WB_STB & ~ack_reg;
      end
   end

   // Writes and read side effects act only on the acknowledged edge
   assign wr_go = I_WB_CYC & I_WB_STB & ack_reg & I_WB_WE;
   assign rd_go = I_WB_CYC & I_WB_STB & ack_reg & ~I_WB_WE;
   assign O_WB_ACK = ack_reg;
   assign O_WB_DAT = rdat_reg;

   // Channels past the last input have no flag, enable or mask bit
   assign result_in_range = I_RESULT_CHANNEL < 5'(`NUM_CHANNELS);

   // an enabled channel result feeds the common interrupt
   assign chan_irq_any = I_RESULT_VALID && result_in_range && irq_en_reg[I_RESULT_CHANNEL];

   // Interrupt enable halves; only five bits exist in the high half
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         irq_en_reg <= `RESET_MASK;
      end else if (wr_go && I_WB_ADR == `OFS_IE_LOW) begin
         if (I_WB_SEL[0]) begin
            irq_en_reg[7:0] <= I_WB_DAT[7:0];
         end
         if (I_WB_SEL[1]) begin
            irq_en_reg[15:8] <= I_WB_DAT[15:8];
         end
      end else if (wr_go && I_WB_ADR == `OFS_IE_HIGH && I_WB_SEL[0]) begin
         irq_en_reg[20:16] <= I_WB_DAT[4:0];
      end
   end

   genvar c;
   generate
      for (c = 0; c < `NUM_CHANNELS; c++) begin : g_chan
         localparam logic [4:0] CH = 5'(c);
         localparam logic [7:0] TOFS = 8'(`OFS_TRIG_BASE + 4 * (c / 2));
         localparam int FLSB = (c % 2 == 1) ? `TRIG_ODD_LSB : `TRIG_EVEN_LSB;
         localparam int LANE = (c % 2 == 1) ? 1 : 0;
         logic set_rdy;
         logic clr_rdy;
         assign set_rdy = I_RESULT_VALID && I_RESULT_CHANNEL == CH;
         assign clr_rdy = I_BUF_READ && I_BUF_READ_CHANNEL == CH;

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               ready_reg[c] <= 1'b0;
            end else if (set_rdy) begin
               ready_reg[c] <= 1'b1;
            end else if (clr_rdy) begin
               ready_reg[c] <= 1'b0;
            end
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               trig_src_reg[c] <= 5'h00;
            end else if (wr_go && I_WB_ADR == TOFS && I_WB_SEL[LANE]) begin
               trig_src_reg[c] <= I_WB_DAT[FLSB +: 5];
            end
         end

         // Decoded per code so a reserved code can never pass a stray source
         logic code_ok;
         always_comb begin
            case (trig_src_reg[c])
               5'h00: code_ok = 1'b0;
               5'h01: code_ok = 1'b1;
               5'h02: code_ok = 1'b1;
               5'h03: code_ok = 1'b0;
               // first-side PWM, trigger 1 then 2
               5'h04: code_ok = 1'b1;
               5'h05: code_ok = 1'b1;
               5'h06: code_ok = 1'b1;
               5'h07: code_ok = 1'b1;
               5'h08: code_ok = 1'b1;
               5'h09: code_ok = 1'b1;
               5'h0A: code_ok = 1'b1;
               5'h0B: code_ok = 1'b1;
               5'h0C: code_ok = 1'b0;
               5'h0D: code_ok = 1'b0;
               5'h0E: code_ok = 1'b0;
               5'h0F: code_ok = 1'b0;
               5'h10: code_ok = 1'b0;
               5'h11: code_ok = 1'b0;
               5'h12: code_ok = 1'b0;
               5'h13: code_ok = 1'b0;
               5'h14: code_ok = 1'b1;
               5'h15: code_ok = 1'b1;
               5'h16: code_ok = 1'b1;
               5'h17: code_ok = 1'b1;
               // second PWM, logic cells, sequencer, pin
               5'h18: code_ok = 1'b1;
               5'h19: code_ok = 1'b1;
               5'h1A: code_ok = 1'b1;
               5'h1B: code_ok = 1'b1;
               5'h1C: code_ok = 1'b1;
               5'h1D: code_ok = 1'b1;
               5'h1E: code_ok = 1'b1;
               5'h1F: code_ok = 1'b1;
               default: code_ok = 1'b0;
            endcase
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               trig_reg[c] <= 1'b0;
            end else begin
               trig_reg[c] <= code_ok & I_TRIGGER_SOURCES[trig_src_reg[c]];
            end
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               chan_irq_reg[c] <= 1'b0;
            end else begin
               chan_irq_reg[c] <= set_rdy & irq_en_reg[c];
            end
         end
      end
   endgenerate

   genvar x;
   generate
      for (x = 0; x < `NUM_CMPS; x++) begin : g_cmp
         localparam logic [7:0] COFS = 8'(`OFS_CMP_BASE + `CMP_STRIDE * x + `CMP_CON_OFS);
         localparam logic [7:0] MOFS = 8'(`OFS_CMP_BASE + `CMP_STRIDE * x + `CMP_MASK_OFS);
         logic [7:0] ctl_reg;
         logic stat_reg;
         chan_t chnl_reg;
         chan_mask_t mask_reg;
         sample_t lo;
         sample_t hi;
         logic ge_lo;
         logic ge_hi;
         logic check;
         assign lo = I_CMP_LOW_THRESHOLD[16 * x +: 16];
         assign hi = I_CMP_HIGH_THRESHOLD[16 * x +: 16];
         assign ge_lo = I_RESULT_DATA >= lo;
         assign ge_hi = I_RESULT_DATA >= hi;
         // compare only masked-in channels when on
         assign check = I_RESULT_VALID && ctl_reg[`CON_ON_BIT]
            && result_in_range && mask_reg[I_RESULT_CHANNEL];
         assign cmp_hit[x] = check & (
            (ctl_reg[`CON_WINDOW_INSIDE_CRITERION_BIT] & ge_lo & ~ge_hi)
            | (ctl_reg[`CON_AT_OR_ABOVE_HIGH_CRITERION_BIT] & ge_hi)
            | (ctl_reg[`CON_BELOW_HIGH_CRITERION_BIT] & ~ge_hi)
            | (ctl_reg[`CON_AT_OR_ABOVE_LOW_CRITERION_BIT] & ge_lo)
            | (ctl_reg[`CON_BELOW_LOW_CRITERION_BIT] & ~ge_lo));
         assign cmp_irq_on[x] = ctl_reg[`CON_IRQ_BIT];

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               ctl_reg <= 8'h00;
            end else if (wr_go && I_WB_ADR == COFS && I_WB_SEL[0]) begin
               ctl_reg <= I_WB_DAT[7:0] & `CON_WR_MASK;
            end
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               mask_reg <= `RESET_MASK;
            end else if (wr_go && I_WB_ADR == MOFS) begin
               if (I_WB_SEL[0]) begin
                  mask_reg[7:0] <= I_WB_DAT[7:0];
               end
               if (I_WB_SEL[1]) begin
                  mask_reg[15:8] <= I_WB_DAT[15:8];
               end
               if (I_WB_SEL[2]) begin
                  mask_reg[20:16] <= I_WB_DAT[20:16];
               end
            end
         end

         // event sets; read of channel field or switch-off clears
         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               stat_reg <= 1'b0;
            end else if (!ctl_reg[`CON_ON_BIT]) begin
               stat_reg <= 1'b0;
            end else if (cmp_hit[x]) begin
               stat_reg <= 1'b1;
            end else if (rd_go && I_WB_ADR == COFS) begin
               stat_reg <= 1'b0;
            end
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               chnl_reg <= 5'h00;
            end else if (cmp_hit[x]) begin
               chnl_reg <= I_RESULT_CHANNEL;
            end
         end

         assign con_rd[x] = {ctl_reg[7:6], stat_reg, ctl_reg[4:0]};
         assign chnl_rd[x] = chnl_reg;
         assign cmask_rd[x] = mask_reg;
      end
   endgenerate

   // common interrupt from channels and comparators
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         common_irq_reg <= 1'b0;
         cmp_event_reg <= 4'h0;
      end else begin
         common_irq_reg <= chan_irq_any || |(cmp_hit & cmp_irq_on);
         cmp_event_reg <= cmp_hit;
      end
   end

   assign O_CHANNEL_TRIGGER = trig_reg;
   assign O_CHANNEL_IRQ = chan_irq_reg;
   assign O_COMMON_IRQ = common_irq_reg;
   assign O_CMP_EVENT = cmp_event_reg;

   // read mux; unmapped and unused bits read zero
   always_comb begin
      rdat_next = 32'h0000_0000;
      case (I_WB_ADR)
         `OFS_IE_LOW: rdat_next[15:0] = irq_en_reg[15:0];
         `OFS_IE_HIGH: rdat_next[4:0] = irq_en_reg[20:16];
         `OFS_RDY_LOW: rdat_next[15:0] = ready_reg[15:0];
         `OFS_RDY_HIGH: rdat_next[4:0] = ready_reg[20:16];
         default: begin
            for (int i = 0; i < `NUM_TRIG_REGS; i++) begin
               if (I_WB_ADR == 8'(`OFS_TRIG_BASE + 4 * i)) begin
                  rdat_next[4:0] = trig_src_reg[2 * i];
                  if (2 * i + 1 < `NUM_CHANNELS) begin
                     rdat_next[12:8] = trig_src_reg[2 * i + 1];
                  end
               end
            end
            for (int k = 0; k < `NUM_CMPS; k++) begin
               if (I_WB_ADR == 8'(`OFS_CMP_BASE + `CMP_STRIDE * k + `CMP_CON_OFS)) begin
                  rdat_next[15:0] = {3'h0, chnl_rd[k], con_rd[k]};
               end
               if (I_WB_ADR == 8'(`OFS_CMP_BASE + `CMP_STRIDE * k + `CMP_MASK_OFS)) begin
                  rdat_next[20:0] = cmask_rd[k];
               end
            end
         end
      endcase
   end

   // Read data is latched on the first cycle so it is stable when ack is seen
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         rdat_reg <= 32'h0000_0000;
      end else if (I_WB_CYC && I_WB_STB && !ack_reg) begin
         rdat_reg <= rdat_next;
      end
   end
endmodule

// ===== adc_trigger_ready_compare_monitor.sv
// Timing checker for the ADC control block ports
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_trigger_ready_compare_monitor (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire adc_ctrl_pkg::wb_addr_t I_WB_ADR,
   input wire logic I_RESULT_VALID,
   input wire adc_ctrl_pkg::chan_t I_RESULT_CHANNEL,
   input wire logic [31:0] I_TRIGGER_SOURCES,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_WB_ACK,
   input wire logic [20:0] O_CHANNEL_TRIGGER,
   input wire logic [20:0] O_CHANNEL_IRQ,
   input wire logic O_COMMON_IRQ,
   input wire logic [3:0] O_CMP_EVENT
);
   import adc_ctrl_pkg::*;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   a_ack_single_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack held longer than one cycle");
   a_ack_after_request: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not answered in one cycle");
   a_high_half_zero: assert property (O_WB_ACK && ($past(I_WB_ADR) == `OFS_RDY_HIGH ||
      $past(I_WB_ADR) == `OFS_IE_HIGH) |-> O_WB_DAT[31:5] == 27'h0)
      else $error("unused high bits read nonzero");
   a_chan_irq_onehot: assert property (O_CHANNEL_IRQ != 21'h0 |-> $past(I_RESULT_VALID) &&
      O_CHANNEL_IRQ == (21'h1 << $past(I_RESULT_CHANNEL)))
      else $error("channel interrupt without matching result");
   a_chan_irq_common: assert property (O_CHANNEL_IRQ != 21'h0 |-> O_COMMON_IRQ)
      else $error("channel interrupt without common interrupt");
   a_event_has_result: assert property (O_CMP_EVENT != 4'h0 |-> $past(I_RESULT_VALID) &&
      $past(I_RESULT_CHANNEL) <= 5'h14)
      else $error("comparator event without valid result");
   a_common_has_cause: assert property (O_COMMON_IRQ |-> $past(I_RESULT_VALID))
      else $error("common interrupt without result");
   a_trig_idle_zero: assert property ($past(I_TRIGGER_SOURCES) == 32'h0 |->
      O_CHANNEL_TRIGGER == 21'h0)
      else $error("trigger output without source");
endmodule
bind adc_trigger_ready_compare adc_trigger_ready_compare_monitor u_adc_trigger_ready_compare_monitor (.*);

// ===== adc_trigger_ready_compare_tb.sv
// Self-checking bench for the ADC control block
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_trigger_ready_compare_tb;
   import adc_ctrl_pkg::*;
   logic clk, rst, cyc, stb, we, vld, brd, ack, cirq;
   wb_addr_t adr;
   logic [3:0] sel, evt;
   logic [31:0] wdat, q, src, s, rdat;
   chan_t ch, bch;
   sample_t dat;
   logic [63:0] lo, hi;
   logic [20:0] trg, irq;
   int miscompares, cmp_count, ie, rdy, i, k, con[4], msk[4], tr[11];
   adc_trigger_ready_compare u_adc_trigger_ready_compare (.I_CLK(clk), .I_RESET(rst),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
      .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_RESULT_VALID(vld),
      .I_RESULT_CHANNEL(ch), .I_RESULT_DATA(dat), .I_BUF_READ(brd), .I_BUF_READ_CHANNEL(bch),
      .I_CMP_LOW_THRESHOLD(lo), .I_CMP_HIGH_THRESHOLD(hi), .I_TRIGGER_SOURCES(src),
      .O_CHANNEL_TRIGGER(trg), .O_CHANNEL_IRQ(irq), .O_COMMON_IRQ(cirq), .O_CMP_EVENT(evt));
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic v(input int c);
      return c != 0 && c != 3 && (c < 12 || c > 19);
   endfunction
   function automatic logic hit(input int x, input int d);
      int l, h, c;
      l = lo[16 * x +: 16];
      h = hi[16 * x +: 16];
      c = con[x];
      return (c[4] && d >= l && d < h) || (c[3] && d >= h) || (c[2] && d < h) ||
         (c[1] && d >= l) || (c[0] && d < l);
   endfunction
   function automatic logic [31:0] exp_rd(input int a);
      int x;
      x = (a - 64) / 16;
      if (a == 0) return ie & 32'hFFFF;
      if (a == 4) return ie >> 16;
      if (a == 8) return rdy & 32'hFFFF;
      if (a == 12) return rdy >> 16;
      if (a >= 16 && a < 60) return tr[(a - 16) / 4] & (a == 56 ? 32'h1F : 32'h1F1F);
      if (a >= 64 && a < 128 && a % 16 == 0) return con[x];
      if (a >= 64 && a < 128 && a % 16 == 4) return msk[x];
      return 0;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test();
      $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wb(input logic w, input int a, input logic [31:0] d);
      int n, x;
      x = (a - 64) / 16;
      n = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a[7:0];
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      if (n >= 50) begin
         miscompares++;
         finish_test();
      end
      if (w && a == 0) ie = (ie & 32'h1F0000) | (d & 32'hFFFF);
      if (w && a == 4) ie = (ie & 32'hFFFF) | ((d & 32'h1F) << 16);
      if (w && a >= 16 && a < 60) tr[(a - 16) / 4] = d;
      if (w && a >= 64 && a < 128 && a % 16 == 0)
         con[x] = (con[x] & (d[7] ? 32'h1F20 : 32'h1F00)) | (d & 32'hDF);
      if (w && a >= 64 && a < 128 && a % 16 == 4) msk[x] = d & 32'h1FFFFF;
   endtask
   task rd(input int a);
      wb(0, a, 0);
      chk(q, exp_rd(a));
      if (a >= 64 && a < 128 && a % 16 == 0) con[(a - 64) / 16] &= 32'h1FDF;
   endtask
   task res(input chan_t c, input sample_t d);
      int x, bc;
      logic [3:0] e;
      logic ci, b;
      e = 0;
      ci = c <= 20 && ie[c];
      b = s[3];
      bc = s[12:8] % 21;
      for (x = 0; x < 4; x++) begin
         if (c <= 20 && con[x][7] && msk[x][c] && hit(x, d)) begin
            e[x] = 1;
            con[x] = (con[x] & 32'hFF) | 32'h20 | (c << 8);
            ci |= con[x][6];
         end
      end
      @(posedge clk);
      vld <= 1;
      ch <= c;
      dat <= d;
      brd <= b;
      bch <= bc[4:0];
      @(posedge clk);
      vld <= 0;
      brd <= 0;
      @(posedge clk);
      chk(irq, (c <= 20 && ie[c]) ? 32'h1 << c : 32'h0);
      chk(cirq, ci);
      chk(evt, e);
      if (b) rdy &= ~(1 << bc);
      if (c <= 20) rdy |= 1 << c;
   endtask
   initial begin
      {cyc, stb, we, vld, brd, adr, wdat, ch, dat, bch, lo, hi, src} = '0;
      ie = 0;
      rdy = 0;
      con = '{default: 0};
      msk = '{default: 0};
      tr = '{default: 0};
      s = 32'hAFD4;
      sel = 4'hF;
      rst = 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      for (i = 0; i < 132; i += 4) rd(i);
      repeat (2) begin
         for (i = 0; i < 132; i += 4) wb(1, i, rnd());
         for (i = 0; i < 132; i += 4) rd(i);
      end
      for (i = 0; i < 32; i++) begin
         wb(1, 16, i | ((31 - i) << 8));
         src <= (32'h1 << i) | (32'h1 << (31 - i));
         repeat (2) @(posedge clk);
         chk(trg[1:0], {v(31 - i), v(i)});
      end
      src <= 0;
      repeat (4) begin
         wb(1, 0, rnd());
         wb(1, 4, rnd());
         lo <= {rnd(), rnd()} & {4{16'h00FF}};
         hi <= {rnd(), rnd()} & {4{16'h00FF}};
         for (k = 0; k < 4; k++) begin
            wb(1, 64 + 16 * k, rnd() | 32'h80);
            wb(1, 68 + 16 * k, rnd());
         end
         repeat (30) res(rnd() % 23, rnd() & 32'hFF);
         for (i = 0; i < 132; i += 4) rd(i);
         for (k = 0; k < 4; k++) rd(64 + 16 * k);
      end
      hi <= '1;
      for (k = 0; k < 4; k++) begin
         wb(1, 68 + 16 * k, 32'h1FFFFF);
         wb(1, 64 + 16 * k, 32'hC4);
      end
      res(5'h14, 16'h0);
      for (k = 0; k < 4; k++) begin
         wb(1, 64 + 16 * k, 32'h04);
         rd(64 + 16 * k);
      end
      finish_test();
   end
endmodule
